// >>> core/g703_codir_timing_loopback.sv
// two-channel co-directional line interface with timing and loopback modes
`timescale 1ns/10ps
// How it works
// - fixed 64 kbps; rate register has no effect
// - each channel keeps its own configuration
// - octet switch off disables, on gives 8 kHz
// - octet mark is violation at eighth bit
// - switches a,b decode into four timing modes
// - internal timing uses local bit divider
// - loop timing follows recovered line bit clock
// - default is loop timing, octet timing on
// - min remote loopback returns raw line data
// - loopback latch steadies data, holds last good pair on a both-marks sample
// - manchester data encoded, then discarded in min remote loopback
// - receiver keeps feeding manchester side in min remote loopback
// - dual loopback returns manchester data to manchester
// - dual loopback re-encodes line data to line
module g703_codir_timing_loopback import g703_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // classic wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // static strap switches, one bit per channel
   input wire logic [1:0] octet_timing_switch_in,
   input wire logic [1:0] timing_mode_switch_a_in,
   input wire logic [1:0] timing_mode_switch_b_in,
   // line pins
   input wire logic [1:0] line_rx_pos_in,
   input wire logic [1:0] line_rx_neg_in,
   output logic [1:0] line_tx_pos_out,
   output logic [1:0] line_tx_neg_out,
   // internal differential manchester side, bit plus strobe
   input wire logic [1:0] dm_rx_bit_in,
   input wire logic [1:0] dm_rx_strobe_in,
   output logic [1:0] dm_tx_bit_out,
   output logic [1:0] dm_tx_strobe_out,
   output logic [1:0] line_bit_req_out
);
   // whole state of the top in one record
   typedef struct packed {
      line_pair_s [1:0] rx_meta; // first sync stage of line pins
      line_pair_s [1:0] rx_sync; // second sync stage
      line_pair_s [1:0] loop_latch; // steadied copy for remote loopback
      logic [5:0] sw_meta; // first sync stage of switches
      logic [5:0] sw_sync; // second sync stage
      chan_cfg_s [1:0] cfg; // captured switch setting
      logic cfg_done; // capture has happened
      logic [1:0] start_cnt; // wait after release
      logic [1:0] chan_en; // software channel enables
      logic [7:0] rate; // stored, never used for timing
      logic [1:0] viol_seen; // sticky: octet violation received
      logic [1:0] loss_seen; // sticky: receive lock lost
      logic [1:0] lock_prev; // lock one cycle back
      cnt_t [1:0] div; // local bit clock dividers
      logic [1:0] dm_hold; // last bit from manchester side
      line_pair_s [1:0] tx; // line transmit outputs
      bit_strobe_s [1:0] dm_tx; // manchester transmit outputs
      logic [1:0] req; // request for next bit
      logic ack; // wishbone acknowledge
      logic [31:0] rdata; // wishbone read data
   } top_state_s;
   top_state_s s_reg;
   top_state_s s_next;
   // per channel wires between the state and the line codecs
   bit_strobe_s [1:0] dec_rx;
   logic [1:0] dec_viol;
   logic [1:0] dec_lock;
   line_pair_s [1:0] enc_line;
   logic [1:0] enc_tick;
   logic [1:0] enc_data;
   logic [1:0] div_tick;
   // bus helpers
   logic bus_go; // new access in this cycle
   logic bus_wr; // new write in this cycle
   logic [31:0] status_word;
   logic [31:0] rd_word;
   // one codec pair and its steering per channel
   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++) begin : g_chan
         // the local divider runs always but is used only for internal timing
         assign div_tick[gc] = (s_reg.div[gc] == CYC_BIT);
         // block timing: local divider or recovered line clock
         assign enc_tick[gc] = s_reg.chan_en[gc] &&
            ((s_reg.cfg[gc].mode == MODE_INTERNAL) ? div_tick[gc] : dec_rx[gc].strobe);
         // dual loopback feeds the transmitter from the line receiver
         assign enc_data[gc] = (s_reg.cfg[gc].mode == MODE_DUAL) ?
            dec_rx[gc].bit_val : s_reg.dm_hold[gc];
         g703_line_decoder u_dec (
            .sys_clk_in(sys_clk_in),
            .resetn_in(resetn_in),
            .line_in(s_reg.rx_sync[gc]),
            .rx_out(dec_rx[gc]),
            .viol_out(dec_viol[gc]),
            .lock_out(dec_lock[gc])
         );
         g703_line_encoder u_enc (
            .sys_clk_in(sys_clk_in),
            .resetn_in(resetn_in),
            .tick_in(enc_tick[gc]),
            .data_in(enc_data[gc]),
            .octet_en_in(s_reg.cfg[gc].octet_en),
            .line_out(enc_line[gc])
         );
         // outputs straight from the state register
         assign line_tx_pos_out[gc] = s_reg.tx[gc].pos;
         assign line_tx_neg_out[gc] = s_reg.tx[gc].neg;
         assign dm_tx_bit_out[gc] = s_reg.dm_tx[gc].bit_val;
         assign dm_tx_strobe_out[gc] = s_reg.dm_tx[gc].strobe;
         assign line_bit_req_out[gc] = s_reg.req[gc];
      end
   endgenerate
   assign wb_dat_out = s_reg.rdata;
   assign wb_ack_out = s_reg.ack;
   // next state of everything held at the top
   always_comb begin
      s_next = s_reg;
      status_word = '0;
      rd_word = '0;
      bus_go = wb_cyc_in && wb_stb_in && !s_reg.ack;
      bus_wr = bus_go && wb_we_in;
      // switch levels cross in through two stages
      s_next.sw_meta = {timing_mode_switch_b_in, timing_mode_switch_a_in, octet_timing_switch_in};
      s_next.sw_sync = s_reg.sw_meta;
      // take the switches once, after the synchroniser has filled
      if (!s_reg.cfg_done) begin
         if (s_reg.start_cnt == CAPTURE_WAIT) begin
            s_next.cfg_done = 1'b1;
            for (int c = 0; c < 2; c++) begin
               s_next.cfg[c].octet_en = s_reg.sw_sync[c];
               s_next.cfg[c].mode = timing_mode_e'({s_reg.sw_sync[4 + c], s_reg.sw_sync[2 + c]});
            end
         end else begin
            s_next.start_cnt = s_reg.start_cnt + 2'h1;
         end
      end
      // software writes; rate is kept only so it reads back
      if (bus_wr) begin
         if (wb_adr_in == REG_CTRL) begin
            if (wb_sel_in[0]) begin
               s_next.chan_en = wb_dat_in[1:0];
            end
         end else if (wb_adr_in == REG_RATE) begin
            if (wb_sel_in[0]) begin
               s_next.rate = wb_dat_in[7:0];
            end
         end
      end
      // per channel datapath and status
      for (int c = 0; c < 2; c++) begin
         // line pins pass two flops before the decoder sees them
         s_next.rx_meta[c].pos = line_rx_pos_in[c];
         s_next.rx_meta[c].neg = line_rx_neg_in[c];
         s_next.rx_sync[c] = s_reg.rx_meta[c];
         // a both-marks sample is illegal; hold the last good pair instead
         if (!(s_reg.rx_sync[c].pos && s_reg.rx_sync[c].neg)) begin
            s_next.loop_latch[c] = s_reg.rx_sync[c];
         end
         // free running local bit clock
         if (div_tick[c]) begin
            s_next.div[c] = '0;
         end else begin
            s_next.div[c] = s_reg.div[c] + cnt_t'(1);
         end
         // hold the latest bit handed over by the manchester side
         if (dm_rx_strobe_in[c]) begin
            s_next.dm_hold[c] = dm_rx_bit_in[c];
         end
         // line transmitter source
         if (!s_reg.chan_en[c]) begin
            s_next.tx[c] = '0;
         end else if (s_reg.cfg[c].mode == MODE_MIN_REMOTE) begin
            s_next.tx[c] = s_reg.loop_latch[c];
         end else begin
            s_next.tx[c] = enc_line[c];
         end
         // manchester transmitter source
         if (!s_reg.chan_en[c]) begin
            s_next.dm_tx[c] = '0;
         end else if (s_reg.cfg[c].mode == MODE_DUAL) begin
            s_next.dm_tx[c].bit_val = dm_rx_bit_in[c];
            s_next.dm_tx[c].strobe = dm_rx_strobe_in[c];
         end else begin
            s_next.dm_tx[c] = dec_rx[c];
         end
         // ask for a bit only when the manchester side feeds the encoder
         s_next.req[c] = enc_tick[c] && (s_reg.cfg[c].mode != MODE_DUAL);
         // sticky flags: clear first so a same-cycle event wins
         s_next.lock_prev[c] = dec_lock[c];
         if (bus_wr && (wb_adr_in == REG_STATUS) && wb_sel_in[c]) begin
            if (wb_dat_in[c * ST_STRIDE + ST_VIOL]) begin
               s_next.viol_seen[c] = 1'b0;
            end
            if (wb_dat_in[c * ST_STRIDE + ST_LOSS]) begin
               s_next.loss_seen[c] = 1'b0;
            end
         end
         if (dec_rx[c].strobe && dec_viol[c] && dec_lock[c]) begin
            s_next.viol_seen[c] = 1'b1;
         end
         if (s_reg.lock_prev[c] && !dec_lock[c]) begin
            s_next.loss_seen[c] = 1'b1;
         end
         // status byte of this channel
         status_word[c * ST_STRIDE + ST_LOCK] = dec_lock[c];
         status_word[c * ST_STRIDE + ST_VIOL] = s_reg.viol_seen[c];
         status_word[c * ST_STRIDE + ST_LOSS] = s_reg.loss_seen[c];
         status_word[c * ST_STRIDE + ST_OCTET] = s_reg.cfg[c].octet_en;
         status_word[c * ST_STRIDE + ST_MODE +: 2] = s_reg.cfg[c].mode;
      end
      // read mux; unmapped addresses read zero and still acknowledge
      if (wb_adr_in == REG_CTRL) begin
         rd_word[1:0] = s_reg.chan_en;
      end else if (wb_adr_in == REG_STATUS) begin
         rd_word = status_word;
      end else if (wb_adr_in == REG_RATE) begin
         rd_word[7:0] = s_reg.rate;
      end
      // single cycle answer, ack dropped the cycle after
      s_next.ack = bus_go;
      if (bus_go && !wb_we_in) begin
         s_next.rdata = rd_word;
      end
   end
   // state register; the configuration starts at the factory default
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_reg <= '0;
         s_reg.cfg <= {CFG_DEFAULT, CFG_DEFAULT};
         s_reg.chan_en <= CTRL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// >>> core/g703_line_decoder.sv
// line receiver: finds block starts, samples the bit, flags polarity violations
`timescale 1ns/10ps
module g703_line_decoder import g703_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input line_pair_s line_in,
   output bit_strobe_s rx_out,
   output logic viol_out,
   output logic lock_out
);
   typedef struct packed {
      logic prev_mark;
      logic busy;
      cnt_t cnt;
      cnt_t idle;
      logic pol;
      logic prev_pol;
      bit_strobe_s rx;
      logic viol;
      logic lock;
   } dec_state_s;
   dec_state_s s_reg;
   dec_state_s s_next;
   logic mark;
   // blanking over three units hides the second mark of a zero block
   always_comb begin
      s_next = s_reg;
      mark = line_in.pos | line_in.neg;
      s_next.rx.strobe = 1'b0;
      s_next.viol = 1'b0;
      s_next.prev_mark = mark;
      // no block for two bit times drops lock
      if (s_reg.idle != LOSS_LIMIT) begin
         s_next.idle = s_reg.idle + cnt_t'(1);
      end else begin
         s_next.lock = 1'b0;
      end
      if (!s_reg.busy) begin
         if (mark && !s_reg.prev_mark) begin
            s_next.busy = 1'b1;
            s_next.cnt = '0;
            s_next.pol = line_in.pos;
            s_next.idle = '0;
         end
      end else begin
         s_next.cnt = s_reg.cnt + cnt_t'(1);
         if (s_reg.cnt == SAMPLE_AT) begin
            s_next.rx.bit_val = mark;
            s_next.rx.strobe = 1'b1;
            // the block that sets lock has nothing to compare against
            s_next.viol = s_reg.lock && (s_reg.pol == s_reg.prev_pol);
            s_next.prev_pol = s_reg.pol;
            s_next.lock = 1'b1;
         end
         if (s_reg.cnt == BLANK_END) begin
            s_next.busy = 1'b0;
         end
      end
   end
   // state register
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign rx_out = s_reg.rx;
   assign viol_out = s_reg.viol;
   assign lock_out = s_reg.lock;
endmodule

// >>> core/g703_line_encoder.sv
// line transmitter: one four-unit block per bit, alternating polarity, octet violation
`timescale 1ns/10ps
module g703_line_encoder import g703_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic tick_in,
   input wire logic data_in,
   input wire logic octet_en_in,
   output line_pair_s line_out
);
   typedef struct packed {
      logic run;
      cnt_t cnt;
      logic bit_val;
      logic pol;
      bit_idx_t idx;
      line_pair_s line;
   } enc_state_s;
   enc_state_s s_reg;
   enc_state_s s_next;
   logic mark;
   logic viol;
   // a tick starts a new block; without ticks the line falls quiet after one bit
   always_comb begin
      s_next = s_reg;
      mark = 1'b0;
      viol = 1'b0;
      if (tick_in) begin
         s_next.bit_val = data_in;
         s_next.cnt = '0;
         s_next.run = 1'b1;
         viol = octet_en_in && (s_reg.idx == OCTET_LAST);
         s_next.pol = viol ? s_reg.pol : ~s_reg.pol;
         s_next.idx = s_reg.idx + bit_idx_t'(1);
      end else if (s_reg.run) begin
         if (s_reg.cnt == CYC_BIT) begin
            s_next.run = 1'b0;
         end else begin
            s_next.cnt = s_reg.cnt + cnt_t'(1);
         end
      end
      // one is marks in units 0 and 1, zero is marks in units 0 and 2
      if (s_next.run) begin
         if (s_next.cnt < UNIT1) begin
            mark = 1'b1;
         end else if (s_next.bit_val) begin
            mark = (s_next.cnt < UNIT2);
         end else begin
            mark = (s_next.cnt >= UNIT2) && (s_next.cnt < UNIT3);
         end
      end
      s_next.line.pos = mark & s_next.pol;
      s_next.line.neg = mark & ~s_next.pol;
   end
   // state register
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign line_out = s_reg.line;
endmodule

// >>> core/g703_pkg.sv
// shared constants, modes and carrier types for the 64 kbps co-directional channel
package g703_pkg;
   // line and octet rates, and the system clock they are counted against
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int LINE_RATE_KBPS = 64;
   localparam int OCTET_RATE_KHZ = 8;
   localparam int UNITS_PER_BIT = 4;
   localparam int CYC_PER_BIT_I = SYS_CLK_HZ / (LINE_RATE_KBPS * 1000);
   localparam int CYC_PER_UNIT_I = CYC_PER_BIT_I / UNITS_PER_BIT;
   localparam int BITS_PER_OCTET_I = LINE_RATE_KBPS / OCTET_RATE_KHZ;
   // cycle counters, wide enough for the loss timeout
   localparam int CNT_W = 11;
   typedef logic [CNT_W-1:0] cnt_t;
   localparam cnt_t CYC_BIT = cnt_t'(CYC_PER_BIT_I - 1);
   localparam cnt_t UNIT1 = cnt_t'(CYC_PER_UNIT_I);
   localparam cnt_t UNIT2 = cnt_t'(2 * CYC_PER_UNIT_I);
   localparam cnt_t UNIT3 = cnt_t'(3 * CYC_PER_UNIT_I);
   localparam cnt_t SAMPLE_AT = cnt_t'((3 * CYC_PER_UNIT_I) / 2);
   localparam cnt_t BLANK_END = cnt_t'(3 * CYC_PER_UNIT_I);
   localparam cnt_t LOSS_LIMIT = cnt_t'(2 * CYC_PER_BIT_I);
   // bit position inside an octet; the last one carries the violation
   typedef logic [2:0] bit_idx_t;
   localparam bit_idx_t OCTET_LAST = bit_idx_t'(BITS_PER_OCTET_I - 1);
   // cycles after reset release before the switch levels are taken
   localparam logic [1:0] CAPTURE_WAIT = 2'h2;
   // bit 0 is switch a, bit 1 is switch b
   typedef enum logic [1:0] {
      MODE_LOOP = 2'b00,
      MODE_INTERNAL = 2'b01,
      MODE_MIN_REMOTE = 2'b10,
      MODE_DUAL = 2'b11
   } timing_mode_e;
   typedef struct packed {logic pos; logic neg;} line_pair_s;
   typedef struct packed {logic bit_val; logic strobe;} bit_strobe_s;
   typedef struct packed {logic octet_en; timing_mode_e mode;} chan_cfg_s;
   localparam chan_cfg_s CFG_DEFAULT = '{octet_en: 1'b1, mode: MODE_LOOP};
   // register map, byte addresses
   typedef logic [7:0] wb_adr_t;
   localparam wb_adr_t REG_CTRL = 8'h00;
   localparam wb_adr_t REG_STATUS = 8'h04;
   localparam wb_adr_t REG_RATE = 8'h08;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // per channel status byte layout
   localparam int ST_STRIDE = 8;
   localparam int ST_LOCK = 0;
   localparam int ST_VIOL = 1;
   localparam int ST_LOSS = 2;
   localparam int ST_OCTET = 3;
   localparam int ST_MODE = 4;
endpackage

// >>> dv/g703_codir_timing_loopback_props.sv
// checker: register handshake and channel 0 timing and loopback paths
`timescale 1ns/10ps
module g703_codir_timing_loopback_props import g703_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic [1:0] timing_mode_switch_a_in,
   input wire logic [1:0] timing_mode_switch_b_in,
   input wire logic [1:0] line_rx_pos_in,
   input wire logic [1:0] line_rx_neg_in,
   input wire logic [1:0] line_tx_pos_out,
   input wire logic [1:0] line_tx_neg_out,
   input wire logic [1:0] dm_rx_bit_in,
   input wire logic [1:0] dm_rx_strobe_in,
   input wire logic [1:0] dm_tx_bit_out,
   input wire logic [1:0] dm_tx_strobe_out,
   input wire logic [1:0] line_bit_req_out
);
   logic [1:0] mode_reg; // channel 0 strap mode, held from reset
   logic [3:0] age_reg; // cycles since release, saturating
   logic [15:0] gap_reg; // cycles since the last bit request
   logic seen_reg; // a bit request was seen since release
   logic ok; // straps taken, mode paths live
   assign ok = (age_reg == 4'hf);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   // straps only count while reset holds, later moves are ignored
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         mode_reg <= {timing_mode_switch_b_in[0], timing_mode_switch_a_in[0]};
      end
   end
   // age and request spacing, cleared by reset
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         age_reg <= 4'h0;
         gap_reg <= 16'h0;
         seen_reg <= 1'b0;
      end else begin
         if (!ok) begin
            age_reg <= age_reg + 4'h1;
         end
         if (line_bit_req_out[0]) begin
            gap_reg <= 16'h0;
            seen_reg <= 1'b1;
         end else if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + 16'h1;
         end
      end
   end
   property p_ack_next;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   property p_ack_pulse;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_tx_excl;
      !(line_tx_pos_out[0] && line_tx_neg_out[0]);
   endproperty
   a_tx_excl: assert property (p_tx_excl) else $error("both line marks high");
   property p_min_pos;
      ok && mode_reg == MODE_MIN_REMOTE && $rose(line_rx_pos_in[0]) |-> ##[1:6] line_tx_pos_out[0];
   endproperty
   a_min_pos: assert property (p_min_pos) else $error("positive mark not looped");
   property p_min_neg;
      ok && mode_reg == MODE_MIN_REMOTE && $rose(line_rx_neg_in[0]) |-> ##[1:6] line_tx_neg_out[0];
   endproperty
   a_min_neg: assert property (p_min_neg) else $error("negative mark not looped");
   property p_dual_dm;
      ok && mode_reg == MODE_DUAL && dm_rx_strobe_in[0] |=>
         dm_tx_strobe_out[0] && dm_tx_bit_out[0] == $past(dm_rx_bit_in[0]);
   endproperty
   a_dual_dm: assert property (p_dual_dm) else $error("manchester bit not echoed");
   property p_dual_noreq;
      ok && mode_reg == MODE_DUAL |-> !line_bit_req_out[0];
   endproperty
   a_dual_noreq: assert property (p_dual_noreq) else $error("bit request in dual loop");
   property p_int_period;
      ok && seen_reg && mode_reg == MODE_INTERNAL && line_bit_req_out[0] |-> gap_reg == 16'h0270;
   endproperty
   a_int_period: assert property (p_int_period) else $error("internal bit period wrong");
   property p_dm_pulse;
      dm_tx_strobe_out[0] |=> !dm_tx_strobe_out[0];
   endproperty
   a_dm_pulse: assert property (p_dm_pulse) else $error("manchester strobe too long");
endmodule
bind g703_codir_timing_loopback g703_codir_timing_loopback_props u_props (.sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .timing_mode_switch_a_in(timing_mode_switch_a_in), .timing_mode_switch_b_in(timing_mode_switch_b_in),
   .line_rx_pos_in(line_rx_pos_in), .line_rx_neg_in(line_rx_neg_in), .line_tx_pos_out(line_tx_pos_out),
   .line_tx_neg_out(line_tx_neg_out), .dm_rx_bit_in(dm_rx_bit_in), .dm_rx_strobe_in(dm_rx_strobe_in),
   .dm_tx_bit_out(dm_tx_bit_out), .dm_tx_strobe_out(dm_tx_strobe_out), .line_bit_req_out(line_bit_req_out));

// >>> dv/g703_codir_timing_loopback_tb.sv
// testbench: strap modes, line coding, loopbacks and registers
`timescale 1ns/10ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH at %0t: got %0h want %0h", $time, (g), (e)); end end
module g703_codir_timing_loopback_tb;
   import g703_pkg::*;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
   wb_adr_t adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack;
   logic [1:0] oct = 2'h0, sa = 2'h0, sb = 2'h0; // straps
   logic [1:0] dmb = 2'h0, dms = 2'h0, pen = 2'h0; // manchester input, partner enables
   wire [1:0] rxp, rxn; // line from the partners
   logic [1:0] txp, txn, dtb, dts, req;
   int bad_count = 0, check_count = 0;
   // straps per run: ch0 internal/min/dual/loop, ch1 min/internal/loop/dual
   logic [1:0] oct_tab[4] = '{2'h1, 2'h0, 2'h1, 2'h1};
   logic [1:0] a_tab[4] = '{2'h1, 2'h2, 2'h1, 2'h2};
   logic [1:0] b_tab[4] = '{2'h2, 2'h1, 2'h1, 2'h2};
   always #12.5 sys_clk_in = ~sys_clk_in;
   g703_codir_timing_loopback uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .octet_timing_switch_in(oct), .timing_mode_switch_a_in(sa),
      .timing_mode_switch_b_in(sb), .line_rx_pos_in(rxp), .line_rx_neg_in(rxn), .line_tx_pos_out(txp),
      .line_tx_neg_out(txn), .dm_rx_bit_in(dmb), .dm_rx_strobe_in(dms), .dm_tx_bit_out(dtb),
      .dm_tx_strobe_out(dts), .line_bit_req_out(req));
   g703_line_partner far0 (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .en_in(pen[0]),
      .pos_out(rxp[0]), .neg_out(rxn[0]));
   g703_line_partner far1 (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .en_in(pen[1]),
      .pos_out(rxp[1]), .neg_out(rxn[1]));
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one classic cycle, held until ack is seen at an edge
   task automatic wb(input logic w, input wb_adr_t a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      `CHECK(ack, 1'b1)
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // mode and octet bits of both channels
   task automatic status(input int k);
      logic [31:0] q;
      wb(1'b0, REG_STATUS, 32'h0, q);
      for (int c = 0; c < 2; c++) `CHECK(q[8*c+3 +: 3], {b_tab[k][c], a_tab[k][c], oct_tab[k][c]})
   endtask
   // 17 block starts: polarity repeats counted, unit 2 must stay empty for ones
   task automatic obs(input int ch, input int want);
      int reps, n;
      logic prev;
      reps = 0;
      prev = 1'b0;
      n = 0;
      while ((txp[ch] | txn[ch]) !== 1'b0 && n < 2000) begin
         @(posedge sys_clk_in);
         n++;
      end
      for (int b = 0; b < 17; b++) begin
         n = 0;
         while ((txp[ch] | txn[ch]) !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_in);
            n++;
         end
         `CHECK(n < 2000, 1'b1)
         if (b > 0 && txp[ch] === prev) reps++;
         prev = txp[ch];
         repeat (390) @(posedge sys_clk_in);
         `CHECK(txp[ch] | txn[ch], 1'b0)
      end
      `CHECK(reps, want)
   endtask
   task automatic chan(input int k, input int ch);
      logic [1:0] m;
      logic v;
      int n;
      m = {b_tab[k][ch], a_tab[k][ch]};
      // loop and internal send this bit; min remote must drop it
      v = (m == MODE_LOOP || m == MODE_INTERNAL);
      @(posedge sys_clk_in);
      dmb[ch] <= v;
      dms[ch] <= 1'b1;
      @(posedge sys_clk_in);
      dms[ch] <= 1'b0;
      @(posedge sys_clk_in);
      if (m == MODE_DUAL) `CHECK({dts[ch], dtb[ch]}, {1'b1, v})
      repeat (1500) @(posedge sys_clk_in);
      obs(ch, (m == MODE_MIN_REMOTE) ? 2 : 2 * oct_tab[k][ch]);
      if (m != MODE_DUAL) begin
         n = 0;
         while (dts[ch] !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_in);
            n++;
         end
         `CHECK(n < 2000, 1'b1)
         `CHECK(dtb[ch], 1'b1)
      end
      // with the line silent only internal timing keeps sending
      pen[ch] <= 1'b0;
      repeat (1500) @(posedge sys_clk_in);
      n = 0;
      repeat (700) begin
         @(posedge sys_clk_in);
         n += int'((txp[ch] | txn[ch]) !== 1'b0);
      end
      `CHECK(n != 0, m == MODE_INTERNAL)
   endtask
   initial begin
      logic [31:0] q;
      for (int k = 0; k < 4; k++) begin
         resetn_in <= 1'b0;
         pen <= 2'h0;
         oct <= oct_tab[k];
         sa <= a_tab[k];
         sb <= b_tab[k];
         repeat (20) @(posedge sys_clk_in);
         resetn_in <= 1'b1;
         // before the straps are taken both channels show the factory default
         wb(1'b0, REG_STATUS, 32'h0, q);
         `CHECK({q[13:11], q[5:3]}, 6'h09)
         repeat (6) @(posedge sys_clk_in);
         status(k);
         // straps moved after capture are ignored
         oct <= ~oct_tab[k];
         sa <= ~a_tab[k];
         sb <= ~b_tab[k];
         repeat (8) @(posedge sys_clk_in);
         status(k);
         if (k == 0) begin
            wb(1'b1, REG_RATE, 32'h0000_00a5, q);
            wb(1'b0, REG_RATE, 32'h0, q);
            `CHECK(q[7:0], 8'ha5)
            wb(1'b0, 8'h0c, 32'h0, q);
            `CHECK(q, 32'h0)
         end
         pen <= 2'h3;
         repeat (3000) @(posedge sys_clk_in);
         fork
            chan(k, 0);
            chan(k, 1);
         join
      end
      test_done();
   end
   // cuts a hang short
   initial begin
      repeat (95000) @(posedge sys_clk_in);
      bad_count++;
      test_done();
   end
endmodule

// >>> dv/g703_line_partner.sv
// line-side partner: sends a stream of ones with octet violations
`timescale 1ns/10ps
module g703_line_partner (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic en_in,
   output logic pos_out,
   output logic neg_out
);
   logic [9:0] cyc_reg; // cycle inside the 625-cycle block
   logic [2:0] idx_reg; // block number inside the octet
   logic pol_reg; // polarity of the current block
   logic mark; // units 0 and 1 marked, as a one is coded
   // the partner owns line timing, loopbacks only echo it
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cyc_reg <= 10'h0;
         idx_reg <= 3'h0;
         pol_reg <= 1'b0;
      end else if (en_in) begin
         if (cyc_reg == 10'h270) begin
            cyc_reg <= 10'h0;
            idx_reg <= idx_reg + 3'h1;
            // the eighth block keeps the polarity of the seventh
            pol_reg <= (idx_reg == 3'h6) ? pol_reg : ~pol_reg;
         end else begin
            cyc_reg <= cyc_reg + 10'h1;
         end
      end
   end
   // idle line carries no mark at all
   assign mark = en_in && (cyc_reg < 10'h138);
   assign pos_out = mark && pol_reg;
   assign neg_out = mark && !pol_reg;
endmodule
